/* shared/io_port_pkg.sv */
// Shared constants for the pin port set: register map, reset values, masks and mode sets.
package io_port_pkg;

	// Port slots; slot 11 is the input-only port.
	localparam int NUM_BIDIR = 11;
	localparam int NUM_SLOTS = 12;
	localparam int P1_IDX = 0;
	localparam int P2_IDX = 1;
	localparam int P3_IDX = 2;
	localparam int P5_IDX = 3;
	localparam int PA_IDX = 4;
	localparam int PB_IDX = 5;
	localparam int PC_IDX = 6;
	localparam int P4_IDX = 11;

	// Word numbers of the registers within a port block of 32 bytes.
	localparam logic [2:0] DIR_WORD = 3'h0;
	localparam logic [2:0] LATCH_WORD = 3'h1;
	localparam logic [2:0] PIN_WORD = 3'h2;
	localparam logic [2:0] PULL_WORD = 3'h3;
	localparam logic [2:0] ODR_WORD = 3'h4;
	localparam logic [3:0] MODE_SLOT = 4'hc;

	// Values after reset.
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam logic [7:0] ODR_RST = 8'h00;
	localparam logic [2:0] MODE_RST = 3'h7;

	// Implemented pins of each slot, in slot order from slot 0 at the right.
	localparam logic [11:0][7:0] WIDTH_MASK = {8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h0f, 8'h0f, 8'h3f, 8'hff, 8'hff};
	// Pins that an on-chip peripheral may drive.
	localparam logic [10:0][7:0] CLAIM_MASK = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h07, 8'h3f, 8'hff, 8'hff};
	// Slots with pull-up control (A to E) and with open-drain control (3 and A).
	localparam logic [10:0] PULL_SLOTS = 11'b001_1111_0000;
	localparam logic [10:0] ODR_SLOTS = 11'b000_0001_0100;

	// Mode sets, one bit per mode number.
	localparam logic [7:0] P1_DDR_MODES = 8'b0111_0110;
	localparam logic [7:0] BC_ADDR_MODES = 8'b0011_0010;
	localparam logic [7:0] BC_DDR_MODES = 8'b0100_0100;
	localparam logic [7:0] A_ADDR_MODES = 8'b0011_0000;
	localparam logic [7:0] A_DDR_MODES = 8'b0100_0000;

endpackage

/* rtl/level_sync.sv */
// Two-stage synchroniser for a bundle of pin levels.
module level_sync #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// Levels in and out.
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* rtl/port_lane.sv */
// One eight-pin port: direction, output latch, pull-up and open-drain state and pin drive.
module port_lane
	import io_port_pkg::*;
#(
	parameter logic [7:0] VALID = 8'hff,
	parameter logic PULL_OK = 1'b0,
	parameter logic ODR_OK = 1'b0
) (
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// Register writes.
	input wire logic wr_dir_in,
	input wire logic wr_latch_in,
	input wire logic wr_pull_in,
	input wire logic wr_odr_in,
	input wire logic [7:0] wdata_in,
	// Override by address or peripheral, and latch lock-out.
	input wire logic [7:0] force_en_in,
	input wire logic [7:0] force_val_in,
	input wire logic [7:0] lock_in,
	// Register contents.
	output logic [7:0] dir_out,
	output logic [7:0] latch_out,
	output logic [7:0] pull_out,
	output logic [7:0] odr_out,
	// Pin drive.
	output logic [7:0] drv_out,
	output logic [7:0] oe_n_out,
	output logic [7:0] pull_en_out
);

	logic [7:0] drive_on;
	logic [7:0] drive_val;
	logic [7:0] pmos_off;

	// An override wins over the latch; the latch drives only unlocked output pins.
	assign drive_on = (force_en_in | (dir_out & ~lock_in)) & VALID;
	assign drive_val = (force_en_in & force_val_in) | (~force_en_in & latch_out);
	// With the high-side driver off a high level releases the pin.
	assign pmos_off = odr_out & drive_val;

	// Register file of the port; unimplemented bits stay zero.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dir_out <= DIR_RST;
			latch_out <= LATCH_RST;
			pull_out <= PULL_RST;
			odr_out <= ODR_RST;
		end else begin
			if (wr_dir_in) dir_out <= wdata_in & VALID;
			if (wr_latch_in) latch_out <= wdata_in & VALID;
			if (wr_pull_in && PULL_OK) pull_out <= wdata_in & VALID;
			if (wr_odr_in && ODR_OK) odr_out <= wdata_in & VALID;
		end
	end

	// Registered pin drive; the pull-up acts only while the pin is an input.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			drv_out <= 8'h00;
			oe_n_out <= 8'hff;
			pull_en_out <= 8'h00;
		end else begin
			drv_out <= drive_val & drive_on & ~pmos_off;
			oe_n_out <= ~(drive_on & ~pmos_off);
			pull_en_out <= pull_out & ~drive_on;
		end
	end

endmodule

/* rtl/io_port_set.sv */
// Pin port set with APB register access, address multiplexing and peripheral pin sharing.
// Behaviour
// - Eleven bidirectional ports plus one input-only port.
// - Each bidirectional port has direction and output latch registers.
// - Every port has a readable pin-state register separate from its latch.
// - The input-only port has no direction register; pins are always inputs.
// - Ports A to E have pull-up control registers per pin.
// - Ports 3 and A have open-drain control disabling the high-side driver.
// - Expanded modes: port 1 low pins input at direction 0, address at 1.
// - Ports B and C in direction modes: input at 0 (reset), address at 1.
// - Port A drives address in modes 4 and 5; direction mode resets to inputs.
// - Port 2 shares its eight pins with two 8-bit timer channels.
// - Port 3 shares six pins with serial channels 0, 1 and two interrupts.
// - The input-only port feeds four analog converter inputs.
// - Port 5 shares three pins with serial channel 2; fourth is plain.
module io_port_set
	import io_port_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External address from the bus controller.
	input wire logic [23:0] ext_addr_in,
	// Peripheral output claims, eight bits per bidirectional port.
	input wire logic [87:0] func_claim_in,
	input wire logic [87:0] func_data_in,
	// Bidirectional pins, eight bits per port.
	input wire logic [87:0] pin_in,
	output logic [87:0] pin_data_out,
	output logic [87:0] pin_oe_n_out,
	output logic [87:0] pull_up_out,
	// Input-only port pins.
	input wire logic [3:0] analog_pin_in,
	// Synchronised pin levels for timers, serial channels and interrupts.
	output logic [87:0] pin_level_out,
	// Levels of the input-only pins towards the analog converter.
	output logic [3:0] analog_input_out
);

	// Synchronised levels of all pins.
	logic [91:0] level_q;

	// Register contents of the bidirectional ports.
	logic [10:0][7:0] dir_all;
	logic [10:0][7:0] latch_all;
	logic [10:0][7:0] pull_all;
	logic [10:0][7:0] odr_all;

	// Pin-state values of every slot.
	logic [11:0][7:0] state_all;

	// Override controls per port.
	logic [10:0][23:0] addr_ctl_all;
	logic [10:0][7:0] force_en_all;
	logic [10:0][7:0] force_val_all;
	logic [10:0][7:0] lock_all;

	// Operating mode.
	logic [2:0] mode_r;

	// APB decode.
	logic [3:0] slot_sel;
	logic [2:0] word_sel;
	logic setup_go;
	logic write_go;
	logic slot_ok;
	logic word_ok;
	logic mode_hit;
	logic addr_bad;
	logic [7:0] reg_val;
	logic [31:0] read_word;

	// Register kind of the addressed word and the reasons for refusal.
	logic dir_word;
	logic latch_word;
	logic pin_word;
	logic pull_word;
	logic odr_word;
	logic bad_range;
	logic bad_align;
	logic pin_write;

	// Write strobes of the bidirectional ports, one bit per port.
	logic [10:0] wr_dir_sel;
	logic [10:0] wr_latch_sel;
	logic [10:0] wr_pull_sel;
	logic [10:0] wr_odr_sel;

	// Contents of the addressed port, one value per register kind.
	logic [7:0] dir_rd;
	logic [7:0] latch_rd;
	logic [7:0] pull_rd;
	logic [7:0] odr_rd;
	logic [7:0] pin_rd;

	// Next values of the bus answer and of the mode.
	logic pready_nxt;
	logic pslverr_nxt;
	logic [31:0] prdata_nxt;
	logic [2:0] mode_nxt;

	// Address drive for a port in the current mode: returns lock, enable and value.
	function automatic logic [23:0] addr_ctl(input int p, input logic [2:0] m, input logic [7:0] d,
		input logic [23:0] a);
		logic [7:0] en;
		logic [7:0] lk;
		logic [7:0] av;
		en = 8'h00;
		lk = 8'h00;
		av = 8'h00;
		case (p)
			P1_IDX: begin
				// Low pins: input at direction 0 (timer inputs stay usable), address at 1.
				lk = P1_DDR_MODES[m] ? 8'h0f : 8'h00;
				en = lk & d;
				av = {4'h0, a[23:20]};
			end
			PA_IDX: begin
				lk = (A_ADDR_MODES[m] || A_DDR_MODES[m]) ? 8'h0f : 8'h00;
				en = A_ADDR_MODES[m] ? 8'h0f : (lk & d);
				av = {4'h0, a[19:16]};
			end
			PB_IDX: begin
				lk = (BC_ADDR_MODES[m] || BC_DDR_MODES[m]) ? 8'hff : 8'h00;
				en = BC_ADDR_MODES[m] ? 8'hff : (lk & d);
				av = a[15:8];
			end
			PC_IDX: begin
				lk = (BC_ADDR_MODES[m] || BC_DDR_MODES[m]) ? 8'hff : 8'h00;
				en = BC_ADDR_MODES[m] ? 8'hff : (lk & d);
				av = a[7:0];
			end
			default: begin
				en = 8'h00;
			end
		endcase
		return {lk, en, av};
	endfunction

	// Every pin level passes two flip-flops before any logic sees it.
	level_sync #(
		.W(92)
	) u_sync (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.async_in({analog_pin_in, pin_in}),
		.sync_out(level_q)
	);

	// Pin levels go to the sharing peripherals whatever drives the pins.
	assign pin_level_out = level_q[87:0];
	// The input-only pins also reach the analog converter.
	assign analog_input_out = level_q[91:88];

	// One lane per bidirectional port with its own override controls.
	genvar g;
	generate
		for (g = 0; g < NUM_BIDIR; g++) begin : gen_port
			assign addr_ctl_all[g] = addr_ctl(g, mode_r, dir_all[g], ext_addr_in);
			assign lock_all[g] = addr_ctl_all[g][23:16];
			// Address output wins, then any peripheral claim allowed on the pin.
			assign force_en_all[g] = addr_ctl_all[g][15:8] | (func_claim_in[g*8+:8] & CLAIM_MASK[g]);
			assign force_val_all[g] = (addr_ctl_all[g][15:8] & addr_ctl_all[g][7:0])
				| (~addr_ctl_all[g][15:8] & func_data_in[g*8+:8]);
			assign state_all[g] = level_q[g*8+:8] & WIDTH_MASK[g];
			// Write strobes of this port, taken at the edge that ends the access cycle.
			assign wr_dir_sel[g] = write_go && slot_sel == 4'(g) && dir_word;
			assign wr_latch_sel[g] = write_go && slot_sel == 4'(g) && latch_word;
			assign wr_pull_sel[g] = write_go && slot_sel == 4'(g) && pull_word;
			assign wr_odr_sel[g] = write_go && slot_sel == 4'(g) && odr_word;

			port_lane #(
				.VALID(WIDTH_MASK[g]),
				.PULL_OK(PULL_SLOTS[g]),
				.ODR_OK(ODR_SLOTS[g])
			) u_lane (
				.core_clk_in(core_clk_in),
				.arst_n_in(arst_n_in),
				.wr_dir_in(wr_dir_sel[g]),
				.wr_latch_in(wr_latch_sel[g]),
				.wr_pull_in(wr_pull_sel[g]),
				.wr_odr_in(wr_odr_sel[g]),
				.wdata_in(pwdata[7:0]),
				.force_en_in(force_en_all[g]),
				.force_val_in(force_val_all[g]),
				.lock_in(lock_all[g]),
				.dir_out(dir_all[g]),
				.latch_out(latch_all[g]),
				.pull_out(pull_all[g]),
				.odr_out(odr_all[g]),
				.drv_out(pin_data_out[g*8+:8]),
				.oe_n_out(pin_oe_n_out[g*8+:8]),
				.pull_en_out(pull_up_out[g*8+:8])
			);
		end
	endgenerate

	// The input-only slot has only its pin-state value.
	assign state_all[P4_IDX] = level_q[91:88] & WIDTH_MASK[P4_IDX];

	// Register map: each port slot takes 32 bytes, starting at the slot number times 0x20.
	// Word 0 is the direction, word 1 the output latch and word 2 the read-only pin state.
	// Word 3 holds the pull-up control of ports A to E, word 4 the open-drain control of ports 3 and A.
	// Slot 11 is the input-only port and offers its pin state word alone.
	// The operating mode sits by itself in word 0 of slot 12.
	// Every other word, and every unaligned or out-of-range address, answers with an error.
	assign slot_sel = paddr[8:5];
	assign word_sel = paddr[4:2];
	assign setup_go = psel && !penable;
	assign write_go = psel && penable && pwrite && pready && !pslverr;

	// Register kind of the addressed word.
	assign dir_word = word_sel == DIR_WORD;
	assign latch_word = word_sel == LATCH_WORD;
	assign pin_word = word_sel == PIN_WORD;
	assign pull_word = word_sel == PULL_WORD;
	assign odr_word = word_sel == ODR_WORD;

	// A slot word exists if the port has that register.
	assign mode_hit = (slot_sel == MODE_SLOT) && dir_word;
	assign slot_ok = slot_sel < NUM_SLOTS;
	assign word_ok = slot_ok && (slot_sel == P4_IDX ? pin_word
		: dir_word || latch_word || pin_word
		|| (pull_word && PULL_SLOTS[slot_sel])
		|| (odr_word && ODR_SLOTS[slot_sel]));

	// Writes to the read-only pin state are refused as well.
	assign bad_range = paddr[11:9] != 3'h0;
	assign bad_align = paddr[1:0] != 2'h0;
	assign pin_write = pwrite && pin_word && !mode_hit;
	assign addr_bad = bad_range || bad_align || !(mode_hit || word_ok) || pin_write;

	// Contents of the addressed port; slots without such a register give zero.
	assign dir_rd = (slot_sel < NUM_BIDIR) ? dir_all[slot_sel] : 8'h00;
	assign latch_rd = (slot_sel < NUM_BIDIR) ? latch_all[slot_sel] : 8'h00;
	assign pull_rd = (slot_sel < NUM_BIDIR) ? pull_all[slot_sel] : 8'h00;
	assign odr_rd = (slot_sel < NUM_BIDIR) ? odr_all[slot_sel] : 8'h00;
	assign pin_rd = slot_ok ? state_all[slot_sel] : 8'h00;

	// Read selection of the addressed register.
	assign reg_val = !word_ok ? 8'h00
		: pin_word ? pin_rd
		: dir_word ? dir_rd
		: latch_word ? latch_rd
		: pull_word ? pull_rd
		: odr_rd;
	assign read_word = mode_hit ? {29'h0, mode_r} : {24'h0, reg_val};

	// Next values: the answer comes in the access cycle right after the setup cycle, with no wait state.
	assign pready_nxt = setup_go;
	assign pslverr_nxt = setup_go && addr_bad;
	assign prdata_nxt = (setup_go && !pwrite && !addr_bad) ? read_word : 32'h0;
	assign mode_nxt = (write_go && mode_hit) ? pwdata[2:0] : mode_r;

	// Operating mode register; steers the address multiplexing.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_r <= MODE_RST;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Ready pulse: high for exactly the one access cycle that follows a setup cycle.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_nxt;
		end
	end

	// Error flag stands with the ready pulse only.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_nxt;
		end
	end

	// Read data stands with the ready pulse and is zero otherwise, so stale data never shows.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prdata <= 32'h0;
		end else begin
			prdata <= prdata_nxt;
		end
	end

endmodule

/* test/io_port_set_chk.sv */
// Checker of the pin port set's bus answers and pin drive.
module io_port_set_chk (
	// Clock, reset and bus.
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and claims.
	input wire logic [87:0] func_claim_in,
	input wire logic [87:0] func_data_in,
	input wire logic [87:0] pin_in,
	input wire logic [87:0] pin_data_out,
	input wire logic [87:0] pin_oe_n_out,
	input wire logic [87:0] pull_up_out,
	input wire logic [3:0] analog_pin_in,
	input wire logic [87:0] pin_level_out,
	input wire logic [3:0] analog_input_out
);
	logic [1:0] up_r;
	wire logic [1:0] up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
	// Counts edges since reset so the synchroniser history is valid.
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) up_r <= 2'h0;
		else up_r <= up_nxt;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	rdy_wait_a: assert property (psel && !penable |=> pready) else $error("no answer");
	rd_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data leak");
	pin_ro_a: assert property (psel && !penable && pwrite && paddr[4:2] == 3'h2 |=> pslverr)
		else $error("pin word written");
	lvl_sync_a: assert property (up_r == 2'h3 |-> pin_level_out == $past(pin_in, 2)
		&& analog_input_out == $past(analog_pin_in, 2)) else $error("level path");
	undriven_zero_a: assert property ((pin_data_out & pin_oe_n_out) == 88'h0) else $error("idle drive");
	pull_place_a: assert property ((pull_up_out & ~pin_oe_n_out) == 88'h0 && pull_up_out[31:0] == 32'h0
		&& pull_up_out[87:72] == 16'h0) else $error("pull-up misplaced");
	gap_bits_a: assert property (&{pin_oe_n_out[39:36], pin_oe_n_out[31:28], pin_oe_n_out[23:22]})
		else $error("missing pin driven");
	timer_claim_a: assert property (func_claim_in[15:8] == 8'hff |=> pin_oe_n_out[15:8] == 8'h00
		&& pin_data_out[15:8] == $past(func_data_in[15:8])) else $error("timer claim lost");
	serial_claim_a: assert property (func_claim_in[26:24] == 3'h7 |=> pin_oe_n_out[26:24] == 3'h0
		&& pin_data_out[26:24] == $past(func_data_in[26:24])) else $error("serial claim lost");
	cover property (pready && pwrite);
	cover property (pready && pslverr);
	cover property (func_claim_in[15:8] == 8'hff);
endmodule

bind io_port_set io_port_set_chk io_port_set_chk_inst (.core_clk_in, .arst_n_in, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .func_claim_in, .func_data_in, .pin_in, .pin_data_out, .pin_oe_n_out,
	.pull_up_out, .analog_pin_in, .pin_level_out, .analog_input_out);

/* test/pin_world.sv */
// Board model: outside drivers, pull-ups and floating wires.
module pin_world (
	// Clock.
	input wire logic core_clk_in,
	// Design drive and outside sources.
	input wire logic [87:0] pin_data_in,
	input wire logic [87:0] pin_oe_n_in,
	input wire logic [87:0] pull_up_in,
	input wire logic [87:0] ext_en_in,
	input wire logic [87:0] ext_val_in,
	// Wire levels.
	output logic [87:0] pin_out
);
	logic float_r = 1'b0;
	// A floating wire shows a level that flips every cycle.
	always @(posedge core_clk_in) float_r <= !float_r;
	// Design drive wins, then an outside source, then the pull-up.
	always_comb begin
		for (int i = 0; i < 88; i++) begin
			pin_out[i] = !pin_oe_n_in[i] ? pin_data_in[i] : ext_en_in[i] ? ext_val_in[i] :
				pull_up_in[i] ? 1'b1 : float_r;
		end
	end
endmodule

/* test/io_port_set_test.sv */
// Self-checking bench of the pin port set.
module io_port_set_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic [23:0] ext_addr_in = 24'h96a53c;
	logic [87:0] func_claim_in = 88'h0;
	logic [87:0] func_data_in = 88'h0;
	logic [87:0] ext_en = 88'h0;
	logic [87:0] ext_val = 88'h0;
	logic [87:0] pin_in;
	logic [87:0] pin_data_out;
	logic [87:0] pin_oe_n_out;
	logic [87:0] pull_up_out;
	logic [87:0] pin_level_out;
	logic [3:0] analog_pin_in = 4'h0;
	logic [3:0] analog_input_out;
	int failures = 0;
	int checks_done = 0;

	io_port_set io_port_set_inst (.core_clk_in, .arst_n_in, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_addr_in, .func_claim_in, .func_data_in, .pin_in, .pin_data_out,
		.pin_oe_n_out, .pull_up_out, .analog_pin_in, .pin_level_out, .analog_input_out);
	pin_world pin_world_inst (.core_clk_in, .pin_data_in(pin_data_out), .pin_oe_n_in(pin_oe_n_out),
		.pull_up_in(pull_up_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin_in));

	// Free-running 40 MHz clock.
	initial forever #12.5 core_clk_in = !core_clk_in;

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [11:0] ad(input int s, input int w);
		return 12'(s * 32 + w * 4);
	endfunction
	// One bus transfer; an idle edge first keeps successive requests apart.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string w, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(w, rd, e);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask

	task automatic t_reset;
		chk("oe_n", pin_oe_n_out, {88{1'b1}});
		chk("drive", pin_data_out, 88'h0);
		chk("pull", pull_up_out, 88'h0);
		rchk("mode", 12'h180, 32'h7);
		rchk("dir b", ad(5, 0), 32'h0);
		apb(1'b0, 12'h200, 32'h0);
		chk("unmapped", err, 1'b1);
	endtask
	task automatic t_latch;
		apb(1'b1, ad(6, 1), 32'ha5);
		apb(1'b1, ad(6, 0), 32'hff);
		wait_n(3);
		chk("pc oe_n", pin_oe_n_out[55:48], 8'h00);
		chk("pc drive", pin_data_out[55:48], 8'ha5);
		rchk("pc latch", ad(6, 1), 32'ha5);
		rchk("pc pins", ad(6, 2), 32'ha5);
		apb(1'b1, ad(6, 2), 32'h0);
		chk("pin write", err, 1'b1);
	endtask
	task automatic t_pins;
		ext_en[47:40] <= 8'hf0;
		ext_val[47:40] <= 8'h30;
		apb(1'b1, ad(5, 3), 32'h0f);
		wait_n(3);
		chk("pb pull", pull_up_out[47:40], 8'h0f);
		rchk("pb pins", ad(5, 2), 32'h3f);
		rchk("pb pull reg", ad(5, 3), 32'h0f);
		rchk("pb latch", ad(5, 1), 32'h0);
		apb(1'b1, ad(0, 3), 32'h0f);
		chk("p1 pull", err, 1'b1);
		ext_en <= 88'h0;
	endtask
	task automatic t_claim;
		apb(1'b1, ad(0, 1), 32'h0f);
		apb(1'b1, ad(0, 0), 32'hff);
		func_claim_in[39:0] <= 40'hffffffffff;
		func_data_in[39:0] <= 40'h5a5a5a5a5a;
		wait_n(3);
		chk("claim oe_n", pin_oe_n_out[39:0], 40'hfff8c00000);
		chk("claim drive", pin_data_out[39:0], 40'h00021a5a5a);
		rchk("p1 pins", ad(0, 2), 32'h5a);
		func_claim_in <= 88'h0;
		wait_n(3);
		chk("p1 latch", pin_data_out[7:0], 8'h0f);
	endtask
	task automatic t_odr;
		apb(1'b1, ad(2, 4), 32'h3f);
		apb(1'b1, ad(2, 1), 32'h0f);
		apb(1'b1, ad(2, 0), 32'h3f);
		wait_n(3);
		chk("od oe_n", pin_oe_n_out[21:16], 6'h0f);
		chk("od drive", pin_data_out[21:16], 6'h00);
		rchk("od reg", ad(2, 4), 32'h3f);
		apb(1'b1, ad(2, 4), 32'h0);
		wait_n(3);
		chk("pp oe_n", pin_oe_n_out[21:16], 6'h00);
		chk("pp drive", pin_data_out[21:16], 6'h0f);
	endtask
	task automatic t_analog;
		analog_pin_in <= 4'ha;
		wait_n(4);
		chk("analog", analog_input_out, 4'ha);
		rchk("p4 pins", ad(11, 2), 32'ha);
		apb(1'b1, ad(11, 0), 32'h1);
		chk("p4 dir", err, 1'b1);
	endtask
	task automatic t_modes;
		apb(1'b1, 12'h180, 32'h4);
		wait_n(3);
		chk("m4 oe_n", pin_oe_n_out[55:32], 24'h0000f0);
		chk("m4 addr", pin_data_out[55:32], 24'h3ca506);
		chk("m4 p1", pin_data_out[7:0], 8'h09);
		apb(1'b1, 12'h180, 32'h6);
		apb(1'b1, ad(0, 0), 32'h01);
		wait_n(3);
		chk("m6 oe_n", pin_oe_n_out[47:32], 16'hffff);
		chk("m6 p1 oe_n", pin_oe_n_out[7:0], 8'hfe);
		chk("m6 p1", pin_data_out[7:0], 8'h01);
		apb(1'b1, ad(5, 0), 32'h0f);
		wait_n(3);
		chk("m6 b oe_n", pin_oe_n_out[47:40], 8'hf0);
		chk("m6 b addr", pin_data_out[47:40], 8'h05);
		apb(1'b1, 12'h180, 32'h2);
		wait_n(3);
		chk("m2 oe_n", pin_oe_n_out[55:32], 24'h00f0ff);
		apb(1'b1, 12'h180, 32'h1);
		wait_n(3);
		chk("m1 oe_n", pin_oe_n_out[55:32], 24'h0000ff);
		chk("m1 addr", pin_data_out[55:40], 16'h3ca5);
	endtask

	// Reset, then each scenario in turn.
	initial begin
		repeat (16) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		@(posedge core_clk_in);
		t_reset;
		t_latch;
		t_pins;
		t_claim;
		t_odr;
		t_analog;
		t_modes;
		close_out;
	end
	// Cuts a hang short.
	initial begin
		repeat (5000) @(posedge core_clk_in);
		failures++;
		close_out;
	end
endmodule
